/* File: pkg/t3sc_pkg.sv */
// Package with register map, field positions and types for the split/capture timer
package t3sc_pkg;
   // Register addresses on the special function register port
   localparam logic [7:0] ADDR_CONTROL = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;
   // Control register field positions
   localparam int BIT_HIGH_OVF = 7;
   localparam int BIT_LOW_OVF = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CAPTURE_SRC = 1;
   localparam int BIT_EXT_CLK = 0;
   // Reset value and byte maximum
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   // Clock dividers
   localparam int CORE_CLOCK_DIV = 12;
   localparam int EXTCLK_DIV = 8;
   // Capture source encodings
   localparam logic CAPTURE_SRC_SOF = 1'b0;
   localparam logic CAPTURE_SRC_LFO = 1'b1;

   // Register bus request, one access per cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } t3sc_req_t;

   // Operating mode
   typedef enum logic [1:0] {
      T3SC_MODE_16_RELOAD,
      T3SC_MODE_8_RELOAD,
      T3SC_MODE_16_CAPTURE,
      T3SC_MODE_8_CAPTURE
   } t3sc_mode_t;
endpackage

/* File: rtl/t3sc_sync.sv */
// Three-stage pin synchroniser with rising-edge pulse output
`timescale 1ns/10ps
module t3sc_sync (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_pulse
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   // Shift chain; only second and third stages are compared
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
         end
      end
   end

   // A change counts once stages two and three agree
   assign level_out = level_reg;
   assign rise_pulse = (s2_reg == s3_reg) && s3_reg && !level_reg;
endmodule

/* File: rtl/t3sc_timer.sv */
// Timer 3: 16-bit or split 8-bit auto-reload timer with event capture
`timescale 1ns/10ps
// Summary of operation
// [R01] Split, no capture: two 8-bit timers each reloading from its own reload byte.
// [R02] Split: run control gates only the high byte; low byte always counts.
// [R03] Byte clock: core clock if select set, else core/12 or external/8.
// [R04] External divided-by-8 source is synchronised to the core clock.
// [R05] High flag sets on high byte wrap, or 16-bit wrap in 16-bit mode.
// [R06] Low flag sets on every low byte wrap in every mode.
// [R07] Interrupt on high overflow; also on low overflow when low enable set.
// [R08] Hardware never clears overflow flags; software clears them by writing control.
// [R09] Software should keep low interrupt enable clear in 16-bit mode.
// [R10] Capture enable picks capture mode; source 0 is start-of-frame, 1 is oscillator rise.
// [R11] Capture, not split: free 16-bit count, capture event copies count into reload.
// [R12] Capture, split: two free 8-bit counts, capture copies both into reload.
// [R13] Outside split, run control 0 stops, 1 lets the timer count.
// [R14] Reload registers hold reload value or last capture; software read/write.
// [R15] Count registers form one 16-bit counter, or two 8-bit counts in split.
// [R16] 16-bit reload: wrap of 0xFFFF loads 16-bit reload value and sets high flag.
// [R17] Capture sources synchronised and edge detected: one capture per event.
module t3sc_timer (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire t3sc_pkg::t3sc_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic high_byte_core_clock_select,
   input wire logic low_byte_core_clock_select,
   input wire logic ext_osc_in,
   input wire logic usb_sof_in,
   input wire logic low_frequency_oscillator_in,
   output logic irq_request,
   output logic capture_pulse,
   output t3sc_pkg::t3sc_mode_t mode
);
   localparam int DIV12_W = $clog2(t3sc_pkg::CORE_CLOCK_DIV);
   localparam int DIV8_W = $clog2(t3sc_pkg::EXTCLK_DIV);
   localparam logic [DIV12_W-1:0] DIV12_LAST = DIV12_W'(t3sc_pkg::CORE_CLOCK_DIV - 1);
   localparam logic [DIV8_W-1:0] DIV8_LAST = DIV8_W'(t3sc_pkg::EXTCLK_DIV - 1);

   // Registers
   logic [7:0] control_reg;
   logic [7:0] reload_low_reg;
   logic [7:0] reload_high_reg;
   logic [7:0] count_low_reg;
   logic [7:0] count_high_reg;
   logic [7:0] rdata_reg;
   logic [DIV12_W-1:0] div12_reg;
   logic [DIV8_W-1:0] div8_reg;
   logic irq_reg;
   logic [7:0] control_next;
   logic [7:0] reload_low_next;
   logic [7:0] reload_high_next;
   logic [7:0] count_low_next;
   logic [7:0] count_high_next;

   // Synchronised pin events
   logic ext_level;
   logic ext_rise;
   logic sof_rise;
   logic lfo_rise;
   logic unused_sof_level;
   logic unused_lfo_level;

   // External oscillator pin into the core clock domain
   t3sc_sync u_sync_ext (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin_in(ext_osc_in),
      .level_out(ext_level),
      .rise_pulse(ext_rise)
   );

   // Start-of-frame event pin
   t3sc_sync u_sync_sof (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin_in(usb_sof_in),
      .level_out(unused_sof_level),
      .rise_pulse(sof_rise)
   );

   // Low-frequency oscillator pin
   t3sc_sync u_sync_lfo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin_in(low_frequency_oscillator_in),
      .level_out(unused_lfo_level),
      .rise_pulse(lfo_rise)
   );

   // Control fields
   wire high_ovf_flag = control_reg[t3sc_pkg::BIT_HIGH_OVF];
   wire low_ovf_flag = control_reg[t3sc_pkg::BIT_LOW_OVF];
   wire low_overflow_irq_enable = control_reg[t3sc_pkg::BIT_LOW_IRQ_EN];
   wire capture_enable = control_reg[t3sc_pkg::BIT_CAPTURE_EN];
   wire split_mode_select = control_reg[t3sc_pkg::BIT_SPLIT];
   wire run_control = control_reg[t3sc_pkg::BIT_RUN];
   wire capture_source_select = control_reg[t3sc_pkg::BIT_CAPTURE_SRC];
   wire external_clock_select = control_reg[t3sc_pkg::BIT_EXT_CLK];

   // Prescaler ticks
   wire tick_div12 = (div12_reg == DIV12_LAST);
   wire tick_div8 = ext_rise && (div8_reg == DIV8_LAST); // [R04]
   wire tick_ext_sel = external_clock_select ? tick_div8 : tick_div12; // [R03]
   wire tick_low = low_byte_core_clock_select ? 1'b1 : tick_ext_sel; // [R03]
   wire tick_high_sel = high_byte_core_clock_select ? 1'b1 : tick_ext_sel; // [R03]

   // Count enables per byte
   wire run_low = split_mode_select ? 1'b1 : run_control; // [R02] [R13]
   wire inc_low = run_low && tick_low;
   wire low_wrap = inc_low && (count_low_reg == t3sc_pkg::BYTE_MAX); // [R06]
   // In 16-bit modes the high byte advances on the low byte carry
   wire inc_high = split_mode_select ? (run_control && tick_high_sel) : low_wrap; // [R15]
   wire high_wrap = inc_high && (count_high_reg == t3sc_pkg::BYTE_MAX); // [R05]
   wire reload_on = !capture_enable; // [R11] [R12]

   // Capture event selection
   wire capture_event = capture_enable &&
      ((capture_source_select == t3sc_pkg::CAPTURE_SRC_SOF) ? sof_rise : lfo_rise); // [R10] [R17]

   // Bus decode
   wire wr_control = sfr_req.wr && (sfr_req.addr == t3sc_pkg::ADDR_CONTROL);
   wire wr_reload_low = sfr_req.wr && (sfr_req.addr == t3sc_pkg::ADDR_RELOAD_LOW);
   wire wr_reload_high = sfr_req.wr && (sfr_req.addr == t3sc_pkg::ADDR_RELOAD_HIGH);
   wire wr_count_low = sfr_req.wr && (sfr_req.addr == t3sc_pkg::ADDR_COUNT_LOW);
   wire wr_count_high = sfr_req.wr && (sfr_req.addr == t3sc_pkg::ADDR_COUNT_HIGH);

   // Counter next values: software write, then reload or increment
   always_comb begin
      count_low_next = count_low_reg;
      count_high_next = count_high_reg;
      if (inc_low) begin
         if (low_wrap && reload_on && split_mode_select) begin
            count_low_next = reload_low_reg; // [R01]
         end else if (low_wrap && reload_on && high_wrap) begin
            count_low_next = reload_low_reg; // [R16]
         end else begin
            count_low_next = count_low_reg + 8'h01; // [R11] [R12]
         end
      end
      if (inc_high) begin
         if (high_wrap && reload_on) begin
            count_high_next = reload_high_reg; // [R01] [R16]
         end else begin
            count_high_next = count_high_reg + 8'h01;
         end
      end
      if (wr_count_low) begin
         count_low_next = sfr_req.wdata;
      end
      if (wr_count_high) begin
         count_high_next = sfr_req.wdata;
      end
   end

   // Reload registers: capture copy or software write
   always_comb begin
      reload_low_next = reload_low_reg;
      reload_high_next = reload_high_reg;
      if (wr_reload_low) begin
         reload_low_next = sfr_req.wdata; // [R14]
      end
      if (wr_reload_high) begin
         reload_high_next = sfr_req.wdata; // [R14]
      end
      if (capture_event) begin
         reload_low_next = count_low_reg; // [R11] [R12] [R14]
         reload_high_next = count_high_reg;
      end
   end

   // Control register: software write, hardware sets win over clears
   always_comb begin
      control_next = control_reg;
      if (wr_control) begin
         control_next = sfr_req.wdata; // [R08]
      end
      if (high_wrap) begin
         control_next[t3sc_pkg::BIT_HIGH_OVF] = 1'b1; // [R05] [R08]
      end
      if (low_wrap) begin
         control_next[t3sc_pkg::BIT_LOW_OVF] = 1'b1; // [R06] [R08]
      end
   end

   // Read mux
   wire [7:0] rdata_sel =
      (sfr_req.addr == t3sc_pkg::ADDR_CONTROL) ? control_reg :
      (sfr_req.addr == t3sc_pkg::ADDR_RELOAD_LOW) ? reload_low_reg :
      (sfr_req.addr == t3sc_pkg::ADDR_RELOAD_HIGH) ? reload_high_reg :
      (sfr_req.addr == t3sc_pkg::ADDR_COUNT_LOW) ? count_low_reg :
      (sfr_req.addr == t3sc_pkg::ADDR_COUNT_HIGH) ? count_high_reg :
      t3sc_pkg::RESET_BYTE;

   // Interrupt request on overflow or capture event
   wire irq_cause = high_wrap || (low_wrap && low_overflow_irq_enable) || capture_event; // [R07]
   // Level request while a flag that is enabled stays set
   wire irq_next = timer_irq_enable &&
      (irq_cause || control_next[t3sc_pkg::BIT_HIGH_OVF] ||
      (control_next[t3sc_pkg::BIT_LOW_OVF] && low_overflow_irq_enable)); // [R07]

   // Prescalers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         div12_reg <= '0;
         div8_reg <= '0;
      end else begin
         div12_reg <= tick_div12 ? '0 : div12_reg + DIV12_W'(1);
         if (ext_rise) begin
            div8_reg <= div8_reg + DIV8_W'(1); // [R04]
         end
      end
   end

   // State registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         control_reg <= t3sc_pkg::RESET_BYTE;
         reload_low_reg <= t3sc_pkg::RESET_BYTE;
         reload_high_reg <= t3sc_pkg::RESET_BYTE;
         count_low_reg <= t3sc_pkg::RESET_BYTE;
         count_high_reg <= t3sc_pkg::RESET_BYTE;
      end else begin
         control_reg <= control_next;
         reload_low_reg <= reload_low_next;
         reload_high_reg <= reload_high_next;
         count_low_reg <= count_low_next;
         count_high_reg <= count_high_next;
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= t3sc_pkg::RESET_BYTE;
         irq_reg <= 1'b0;
      end else begin
         if (sfr_req.rd) begin
            rdata_reg <= rdata_sel;
         end
         irq_reg <= irq_next;
      end
   end

   // Mode indication
   always_comb begin
      case ({capture_enable, split_mode_select})
         2'b00: mode = t3sc_pkg::T3SC_MODE_16_RELOAD;
         2'b01: mode = t3sc_pkg::T3SC_MODE_8_RELOAD;
         2'b10: mode = t3sc_pkg::T3SC_MODE_16_CAPTURE;
         2'b11: mode = t3sc_pkg::T3SC_MODE_8_CAPTURE;
         default: mode = t3sc_pkg::T3SC_MODE_16_RELOAD;
      endcase
   end

   assign sfr_rdata = rdata_reg;
   assign irq_request = irq_reg;
   assign capture_pulse = capture_event;

   // Unused flag and synchronised pin level taps; the flags stay readable through the control register
   wire unused_ok = ^{high_ovf_flag, low_ovf_flag, ext_level, unused_sof_level,
      unused_lfo_level};
endmodule

/* File: tb/t3sc_chk.sv */
// Port-level property checker for the split/capture timer
`timescale 1ns/10ps
module t3sc_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire t3sc_pkg::t3sc_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic usb_sof_in,
   input wire logic low_frequency_oscillator_in,
   input wire logic irq_request,
   input wire logic capture_pulse,
   input wire t3sc_pkg::t3sc_mode_t mode
);
   logic [7:0] ctl_reg;
   logic [7:0] rl_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Shadow of software writes
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ctl_reg <= 8'h00;
         rl_reg <= 8'h00;
      end else if (sfr_req.wr) begin
         if (sfr_req.addr == 8'h91) ctl_reg <= sfr_req.wdata;
         if (sfr_req.addr == 8'h92) rl_reg <= sfr_req.wdata;
      end
   end
   // Selected capture source rises
   sequence s_sof_rise;
      $rose(usb_sof_in) && ctl_reg[4] && !ctl_reg[1];
   endsequence
   sequence s_lfo_rise;
      $rose(low_frequency_oscillator_in) && ctl_reg[4] && ctl_reg[1];
   endsequence
   property p_mode;
      mode == t3sc_pkg::t3sc_mode_t'({ctl_reg[4], ctl_reg[3]});
   endproperty
   property p_cap_en;
      capture_pulse |-> ctl_reg[4];
   endproperty
   property p_cap_one;
      capture_pulse |=> !capture_pulse;
   endproperty
   property p_sof;
      s_sof_rise |-> ##[1:6] capture_pulse;
   endproperty
   property p_lfo;
      s_lfo_rise |-> ##[1:6] capture_pulse;
   endproperty
   property p_cap_irq;
      capture_pulse && timer_irq_enable |=> irq_request;
   endproperty
   property p_irq_off;
      !timer_irq_enable |=> !irq_request;
   endproperty
   property p_rl;
      sfr_req.rd && sfr_req.addr == 8'h92 && !ctl_reg[4] |=> sfr_rdata == rl_reg;
   endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   a_cap_en: assert property (p_cap_en) else $error("capture outside capture mode");
   a_cap_one: assert property (p_cap_one) else $error("capture pulse too long");
   a_sof: assert property (p_sof) else $error("frame event not captured");
   a_lfo: assert property (p_lfo) else $error("oscillator edge not captured");
   a_cap_irq: assert property (p_cap_irq) else $error("no request on capture");
   a_irq_off: assert property (p_irq_off) else $error("request while disabled");
   a_rl: assert property (p_rl) else $error("reload low readback wrong");
endmodule

/* File: tb/t3sc_timer_test.sv */
// Self-checking testbench for the split/capture timer
`timescale 1ns/10ps
module t3sc_timer_test;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   t3sc_pkg::t3sc_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic irq_en = 1'b1;
   logic hs = 1'b1;
   logic ls = 1'b1;
   logic [2:0] pins = 3'b000;
   logic irq_request;
   logic capture_pulse;
   t3sc_pkg::t3sc_mode_t mode;
   logic [8:0] exp_q[$];
   logic [8:0] exp_v;
   logic pend = 1'b0;
   int num_errors = 0;
   int samples_checked = 0;
   integer seed = 32'h0a8f_7a0e;
   logic [15:0] r;
   logic [7:0] caps[4] = '{8'h11, 8'h13, 8'h19, 8'h1b};

   t3sc_timer t3sc_timer_inst (
      .ref_clk, .rstn, .sfr_req, .sfr_rdata,
      .timer_irq_enable(irq_en),
      .high_byte_core_clock_select(hs),
      .low_byte_core_clock_select(ls),
      .ext_osc_in(pins[2]),
      .usb_sof_in(pins[0]),
      .low_frequency_oscillator_in(pins[1]),
      .irq_request, .capture_pulse, .mode
   );

   // Clock
   always #12.5 ref_clk = ~ref_clk;

   // One register access, held for one edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= '{w, !w, a, d};
      @(posedge ref_clk);
      sfr_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic i);
      exp_q.push_back({i, e});
      acc(1'b0, a, 8'h00);
   endtask
   task automatic pulse(input int i);
      @(posedge ref_clk) pins[i] <= 1'b1;
      repeat (6) @(posedge ref_clk);
      pins[i] <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic summarize();
      $display("Checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Read data and request compared with oldest note
   always @(posedge ref_clk) pend <= sfr_req.rd;
   always @(negedge ref_clk) begin
      if (pend) begin
         exp_v = exp_q.pop_front();
         samples_checked++;
         if ({irq_request, sfr_rdata} !== exp_v) begin
            num_errors++;
            $display("ERROR irq_rdata expected %h seen %h", exp_v, {irq_request, sfr_rdata});
         end
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      summarize();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int a = 8'h91; a <= 8'h96; a++) rd(a[7:0], 8'h00, 1'b0);
      r = 16'($random(seed));
      wr(8'h92, r[7:0]);
      wr(8'h93, r[15:8]);
      rd(8'h92, r[7:0], 1'b0);
      rd(8'h93, r[15:8], 1'b0);
      // 16-bit wrap, flags, stop
      wr(8'h94, 8'hfe);
      wr(8'h95, 8'hff);
      wr(8'h92, 8'h34);
      wr(8'h93, 8'h12);
      wr(8'h91, 8'h04);
      repeat (6) @(posedge ref_clk);
      rd(8'h91, 8'hc4, 1'b1);
      rd(8'h95, 8'h12, 1'b1);
      @(posedge ref_clk) irq_en <= 1'b0;
      rd(8'h91, 8'hc4, 1'b0);
      irq_en <= 1'b1;
      wr(8'h91, 8'h00);
      rd(8'h91, 8'h00, 1'b0);
      wr(8'h94, 8'h55);
      repeat (20) @(posedge ref_clk);
      rd(8'h94, 8'h55, 1'b0);
      // Low carry into high byte, stopped one count later
      wr(8'h94, 8'hff);
      wr(8'h95, 8'h30);
      wr(8'h91, 8'h04);
      wr(8'h91, 8'h00);
      rd(8'h95, 8'h31, 1'b0);
      rd(8'h94, 8'h01, 1'b0);
      // Split mode
      wr(8'h95, 8'h77);
      wr(8'h94, 8'hf0);
      wr(8'h92, 8'ha0);
      wr(8'h91, 8'h08);
      repeat (30) @(posedge ref_clk);
      rd(8'h91, 8'h48, 1'b0);
      rd(8'h95, 8'h77, 1'b0);
      wr(8'h91, 8'h28);
      repeat (120) @(posedge ref_clk);
      rd(8'h91, 8'h68, 1'b1);
      wr(8'h92, 8'h00);
      wr(8'h94, 8'h00);
      wr(8'h95, 8'hfe);
      wr(8'h93, 8'h60);
      wr(8'h91, 8'h0c);
      repeat (6) @(posedge ref_clk);
      rd(8'h91, 8'h8c, 1'b1);
      // Split reload of each byte: high wraps, then stops one count later
      wr(8'h91, 8'h08);
      wr(8'h95, 8'hff);
      wr(8'h91, 8'h0c);
      wr(8'h91, 8'h08);
      rd(8'h95, 8'h61, 1'b0);
      wr(8'h92, 8'h5a);
      wr(8'h94, 8'hff);
      rd(8'h94, 8'h5a, 1'b0);
      // Divided clock sources
      hs <= 1'b0;
      ls <= 1'b0;
      wr(8'h91, 8'h00);
      wr(8'h94, 8'hf0);
      wr(8'h95, 8'hff);
      wr(8'h91, 8'h04);
      repeat (50) @(posedge ref_clk);
      rd(8'h91, 8'h04, 1'b0);
      wr(8'h91, 8'h00);
      wr(8'h94, 8'hff);
      wr(8'h91, 8'h05);
      repeat (40) @(posedge ref_clk);
      rd(8'h91, 8'h05, 1'b0);
      repeat (24) begin
         repeat (2) @(posedge ref_clk);
         pins[2] <= ~pins[2];
      end
      repeat (6) @(posedge ref_clk);
      rd(8'h91, 8'hc5, 1'b1);
      // Twelve synced rises give one tick: single 16-bit reload, then frozen
      rd(8'h95, 8'h60, 1'b1);
      rd(8'h94, 8'h5a, 1'b1);
      // Capture in both capture modes from both sources, counter frozen
      for (int m = 0; m < 4; m++) begin
         wr(8'h91, caps[m]);
         r = 16'($random(seed));
         wr(8'h94, r[7:0]);
         wr(8'h95, r[15:8]);
         pulse(caps[m][1]);
         wr(8'h94, ~r[7:0]);
         pulse(!caps[m][1]);
         rd(8'h92, r[7:0], 1'b0);
         rd(8'h93, r[15:8], 1'b0);
      end
      summarize();
   end
endmodule

bind t3sc_timer t3sc_chk t3sc_chk_inst (
   .ref_clk, .rstn, .sfr_req, .sfr_rdata, .timer_irq_enable,
   .usb_sof_in, .low_frequency_oscillator_in, .irq_request, .capture_pulse, .mode
);
